//--- sqic_pkg.sv
package sqic_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_P2_Q0     = 8'hB6;
    localparam logic [7:0] ADDR_P3_Q3     = 8'hB7;
    localparam logic [7:0] ADDR_P3_Q2     = 8'hB8;
    localparam logic [7:0] ADDR_P3_Q1     = 8'hB9;
    localparam logic [7:0] ADDR_P3_Q0     = 8'hBA;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'hBB;
    localparam logic [7:0] ADDR_LC_STATUS = 8'hBC;
    localparam logic [7:0] ADDR_PAUSE_LIM = 8'hBD;
    localparam logic [7:0] ADDR_THRESH    = 8'hC0;
    localparam logic [7:0] ADDR_REGUL     = 8'hC1;

    // ------------------------------------------------------------------
    // field positions and values after reset
    // ------------------------------------------------------------------
    localparam int         SEL_BIT        = 7;
    localparam logic       SEL_RST        = 1'b1;
    localparam logic [6:0] WEIGHT_Q3      = 7'h08;
    localparam logic [6:0] WEIGHT_Q2      = 7'h04;
    localparam logic [6:0] WEIGHT_Q1      = 7'h02;
    localparam logic [6:0] WEIGHT_Q0      = 7'h01;
    localparam logic [7:0] IRQ_EN_RST     = 8'h00;
    localparam logic [7:0] LC_STATUS_RST  = 8'h00;
    localparam int         LC_P12_BIT     = 7;
    localparam int         LC_P3_BIT      = 2;
    localparam int         LC_P2_BIT      = 1;
    localparam int         LC_P1_BIT      = 0;
    localparam logic [7:0] PAUSE_LIM_RST  = 8'h00;
    localparam int         PAUSE_EN_BIT   = 0;
    localparam logic [7:0] THRESH_VAL     = 8'h03;
    localparam logic [7:0] REGUL_RST      = 8'h00;
    localparam int         REGUL_DIS_BIT  = 6;
    localparam logic [7:0] REGUL_WR_MASK  = 8'h40;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int         CLK_FREQ_HZ    = 125_000_000;
    localparam int         PAUSE_TIME_MS  = 160;
    localparam int         PAUSE_CYCLES   = (PAUSE_TIME_MS * (CLK_FREQ_HZ / 1000) + 0) < 1 ?
                                            1 : PAUSE_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int         PAUSE_CNT_W    = 25;
endpackage : sqic_pkg

//--- sqic_regs.sv
// Overview of operation
// - all select bits clear, global clear: strict priority
// - select set, four queues: weighted 8:4:2:1
// - select set, two queues: weighted 2:1
// - low seven bits read fixed weights 8,4,2,1
// - eight-bit interrupt enable register, reset zero
// - status bits clear on writing one
// - bit 7 sets on port 1/2 copper change
// - bit 2 sets on port 3 interface change
// - bit 1 sets on port 2 copper change
// - bit 0 sets on port 1 any change
// - limit enabled: invalidate after 160 ms pause
// - regulator bit 6 disables regulator, reset zero
`timescale 1ns/100ps
`default_nettype none
module sqic_regs
    import sqic_pkg::*;
#(
    parameter int PAUSE_LIMIT_CYCLES = sqic_pkg::PAUSE_CYCLES
)(
    input  wire logic       clk,
    input  wire logic       rst_b,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // link state pins
    input  wire logic       p1_copper_link,
    input  wire logic       p1_mii_link,
    input  wire logic       p2_copper_link,
    input  wire logic       p3_mii_link,
    // flow control
    input  wire logic       pause_active,
    output logic            flow_ctrl_invalidate,
    // egress queue scheduling
    input  wire logic       global_prio,
    input  wire logic [2:0] p2_upper_sel,
    input  wire logic       p2_two_queue,
    input  wire logic [3:0] p2_egress_queue_req,
    input  wire logic       p2_egress_queue_take,
    output logic      [3:0] p2_egress_queue_grant,
    output logic            p2_egress_queue_valid,
    input  wire logic       p3_two_queue,
    input  wire logic [3:0] p3_egress_queue_req,
    input  wire logic       p3_egress_queue_take,
    output logic      [3:0] p3_egress_queue_grant,
    output logic            p3_egress_queue_valid,
    // misc outputs
    output logic            irq_out_low,
    output logic            regulator_disable
);
    import sqic_pkg::*;

    // ------------------------------------------------------------------
    // link pin synchronisers and change detect
    // ------------------------------------------------------------------
    // one bit per monitored link, shared by the stages below
    logic [3:0] link_pin;
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] sync_c;
    logic [3:0] link_stable;
    logic [3:0] link_change;

    // order: 0 = p1 copper, 1 = p1 mii, 2 = p2 copper, 3 = p3 mii
    assign link_pin = {p3_mii_link, p2_copper_link, p1_mii_link, p1_copper_link};

    // pins are asynchronous to clk; the third stage keeps a metastable
    // second stage from being counted as a real change
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_link
            // three stages; a change counts once stages two and three agree
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_c[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= link_pin[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                end
            end

            // compare against the stable copy, not the previous sample
            assign link_change[gi] = (sync_b[gi] == sync_c[gi]) &&
                                     (sync_c[gi] != link_stable[gi]);

            // stable copy starts at link-down, so a link up at reset reports once
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    link_stable[gi] <= 1'b0;
                end else if (link_change[gi]) begin
                    link_stable[gi] <= sync_c[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // full eight-bit compare; offsets outside the map decode to nothing,
    // so stray writes there are simply dropped
    wire wr_p2_q0  = reg_wr && (reg_addr == ADDR_P2_Q0);
    wire wr_p3_q3  = reg_wr && (reg_addr == ADDR_P3_Q3);
    wire wr_p3_q2  = reg_wr && (reg_addr == ADDR_P3_Q2);
    wire wr_p3_q1  = reg_wr && (reg_addr == ADDR_P3_Q1);
    wire wr_p3_q0  = reg_wr && (reg_addr == ADDR_P3_Q0);
    wire wr_irq_en = reg_wr && (reg_addr == ADDR_IRQ_EN);
    wire wr_status = reg_wr && (reg_addr == ADDR_LC_STATUS);
    wire wr_pause  = reg_wr && (reg_addr == ADDR_PAUSE_LIM);
    wire wr_regul  = reg_wr && (reg_addr == ADDR_REGUL);

    // ------------------------------------------------------------------
    // queue select bits (only bit 7 is writable)
    // ------------------------------------------------------------------
    // the low seven bits are fixed weights and need no storage;
    // select bits reset to one, so a fresh port runs weighted
    logic       p2_q0_sel;
    logic [3:0] p3_sel;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p2_q0_sel <= SEL_RST;
            p3_sel    <= {4{SEL_RST}};
        end else begin
            if (wr_p2_q0) p2_q0_sel <= reg_wdata[SEL_BIT];
            if (wr_p3_q3) p3_sel[3] <= reg_wdata[SEL_BIT];
            if (wr_p3_q2) p3_sel[2] <= reg_wdata[SEL_BIT];
            if (wr_p3_q1) p3_sel[1] <= reg_wdata[SEL_BIT];
            if (wr_p3_q0) p3_sel[0] <= reg_wdata[SEL_BIT];
        end
    end

    // ------------------------------------------------------------------
    // interrupt enable, pause limit and regulator control
    // ------------------------------------------------------------------
    logic [7:0] link_irq_enable;
    logic [7:0] pause_off_time_limit;
    logic [7:0] core_regulator_control;

    // one register each; writes land at the edge that takes reg_wr
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link_irq_enable        <= IRQ_EN_RST;
            pause_off_time_limit   <= PAUSE_LIM_RST;
            core_regulator_control <= REGUL_RST;
        end else begin
            if (wr_irq_en) link_irq_enable <= reg_wdata;
            if (wr_pause)  pause_off_time_limit <= reg_wdata;
            // reserved bits of the regulator register stay zero
            if (wr_regul)  core_regulator_control <= reg_wdata & REGUL_WR_MASK;
        end
    end

    // output follows the stored bit; reserved bits never reach it
    assign regulator_disable = core_regulator_control[REGUL_DIS_BIT];

    // ------------------------------------------------------------------
    // link change status, write one to clear, set wins
    // ------------------------------------------------------------------
    // status bits 6:3 are never set, so they always read zero;
    // a clear and a pin change in one cycle keep the flag, so no
    // change is lost between a read and its clear
    logic [7:0] link_change_flag;
    logic [7:0] lc_set;
    logic [7:0] lc_clr;
    logic [7:0] next_link_change_flag;

    assign lc_set[LC_P12_BIT] = link_change[0] | link_change[2];
    assign lc_set[6:3]        = 4'h0;
    assign lc_set[LC_P3_BIT]  = link_change[3];
    assign lc_set[LC_P2_BIT]  = link_change[2];
    assign lc_set[LC_P1_BIT]  = link_change[0] | link_change[1];

    // writes to any other offset leave the status alone
    assign lc_clr = wr_status ? reg_wdata : 8'h00;
    // a change landing in the clearing cycle is kept
    assign next_link_change_flag = (link_change_flag & ~lc_clr) | lc_set;

    // single register holds every status bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link_change_flag <= LC_STATUS_RST;
        end else begin
            link_change_flag <= next_link_change_flag;
        end
    end

    // registered pin, so it never glitches on the decode
    // costs one cycle of latency after a flag sets or clears
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_out_low <= 1'b1;
        end else begin
            irq_out_low <= ~|(link_change_flag & link_irq_enable);
        end
    end

    // ------------------------------------------------------------------
    // pause-off time limit
    // ------------------------------------------------------------------
    // the limit counts core clock cycles; the default keeps the full
    // span, and a short value can be passed in for quick runs
    logic [PAUSE_CNT_W-1:0] pause_cnt;
    wire                    pause_limit_en = pause_off_time_limit[PAUSE_EN_BIT];
    wire                    pause_expire   = pause_active && pause_limit_en &&
        (pause_cnt == PAUSE_CNT_W'(PAUSE_LIMIT_CYCLES - 1));

    // counter restarts whenever the pause drops, so only continuous pause counts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pause_cnt <= '0;
        end else if (!pause_active || !pause_limit_en || pause_expire) begin
            pause_cnt <= '0;
        end else begin
            pause_cnt <= pause_cnt + 1'b1;
        end
    end

    // one-cycle request pulse; the counter restarts for the next one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flow_ctrl_invalidate <= 1'b0;
        end else begin
            flow_ctrl_invalidate <= pause_expire;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // reads have no side effect; status bits clear only by writes
    wire [7:0] rd_p2_q0 = {p2_q0_sel, WEIGHT_Q0};
    wire [7:0] rd_p3_q3 = {p3_sel[3], WEIGHT_Q3};
    wire [7:0] rd_p3_q2 = {p3_sel[2], WEIGHT_Q2};
    wire [7:0] rd_p3_q1 = {p3_sel[1], WEIGHT_Q1};
    wire [7:0] rd_p3_q0 = {p3_sel[0], WEIGHT_Q0};
    logic [7:0] rd_mux;

    // combinational select of the addressed register
    always_comb begin
        unique case (reg_addr)
            ADDR_P2_Q0:     rd_mux = rd_p2_q0;
            ADDR_P3_Q3:     rd_mux = rd_p3_q3;
            ADDR_P3_Q2:     rd_mux = rd_p3_q2;
            ADDR_P3_Q1:     rd_mux = rd_p3_q1;
            ADDR_P3_Q0:     rd_mux = rd_p3_q0;
            ADDR_IRQ_EN:    rd_mux = link_irq_enable;
            ADDR_LC_STATUS: rd_mux = link_change_flag;
            ADDR_PAUSE_LIM: rd_mux = pause_off_time_limit;
            ADDR_THRESH:    rd_mux = THRESH_VAL;
            ADDR_REGUL:     rd_mux = core_regulator_control;
            default:        rd_mux = 8'h00;     // unmapped reads as zero
        endcase
    end

    // read data holds until the next read strobe
    // reading an unmapped offset still updates the data, to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // egress schedulers for ports 2 and 3
    // ------------------------------------------------------------------
    // strict only when every select bit and the global bit are clear
    // port 2 upper select bits live outside this block and come in
    // as levels; only its queue 0 select bit is kept here
    wire p2_weighted = (|p2_upper_sel) | p2_q0_sel | global_prio;
    wire p3_weighted = (|p3_sel) | global_prio;

    sqic_sched u_p2_sched (
        .clk         (clk),
        .rst_b       (rst_b),
        .weighted    (p2_weighted),
        .two_queue   (p2_two_queue),
        .queue_req   (p2_egress_queue_req),
        .take        (p2_egress_queue_take),
        .grant       (p2_egress_queue_grant),
        .grant_valid (p2_egress_queue_valid)
    );

    // port 3 keeps all four select bits locally
    sqic_sched u_p3_sched (
        .clk         (clk),
        .rst_b       (rst_b),
        .weighted    (p3_weighted),
        .two_queue   (p3_two_queue),
        .queue_req   (p3_egress_queue_req),
        .take        (p3_egress_queue_take),
        .grant       (p3_egress_queue_grant),
        .grant_valid (p3_egress_queue_valid)
    );
endmodule : sqic_regs
`default_nettype wire

//--- sqic_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module sqic_regs_sva
    import sqic_pkg::*;
#(
    parameter int PAUSE_LIMIT_CYCLES = 16
)(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       pause_active,
    input  wire logic       flow_ctrl_invalidate,
    input  wire logic       p2_two_queue,
    input  wire logic [3:0] p2_egress_queue_req,
    input  wire logic       p2_egress_queue_take,
    input  wire logic [3:0] p2_egress_queue_grant,
    input  wire logic       p2_egress_queue_valid,
    input  wire logic [3:0] p3_egress_queue_req,
    input  wire logic       p3_egress_queue_take,
    input  wire logic [3:0] p3_egress_queue_grant,
    input  wire logic       p3_egress_queue_valid,
    input  wire logic       irq_out_low,
    input  wire logic       regulator_disable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // helper: run of pause cycles, saturating so it never wraps
    // ------------------------------------------------------------------
    logic [31:0] pause_run;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) pause_run <= '0;
        else if (!pause_active) pause_run <= '0;
        else if (pause_run != '1) pause_run <= pause_run + 32'h1;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    thresh_ro_a: assert property (reg_rd && reg_addr == ADDR_THRESH |=> reg_rdata == THRESH_VAL)
        else $error("threshold register reads wrong");
    weight_ro_a: assert property (reg_rd && reg_addr == ADDR_P3_Q2 |=> reg_rdata[6:0] == WEIGHT_Q2)
        else $error("queue weight field reads wrong");
    status_rsv_a: assert property (reg_rd && reg_addr == ADDR_LC_STATUS |=> reg_rdata[6:3] == 4'h0)
        else $error("reserved status bits set");
    regul_wr_a: assert property (reg_wr && reg_addr == ADDR_REGUL |=> regulator_disable == $past(reg_wdata[6]))
        else $error("regulator output does not follow bit 6");
    grant_hot_a: assert property (p3_egress_queue_valid |-> $onehot(p3_egress_queue_grant))
        else $error("port 3 grant not one-hot");
    no_req_a: assert property (p3_egress_queue_take && p3_egress_queue_req == 4'h0 |=> !p3_egress_queue_valid)
        else $error("grant without any request");
    grant_req_a: assert property (p2_egress_queue_valid |-> (p2_egress_queue_grant & $past(p2_egress_queue_req)) != 4'h0)
        else $error("port 2 granted an empty queue");
    take_ans_a: assert property (p2_egress_queue_take && !p2_two_queue && p2_egress_queue_req != 4'h0 |-> ##[1:2] p2_egress_queue_valid)
        else $error("port 2 take not answered");
    pause_run_a: assert property (flow_ctrl_invalidate |-> pause_run >= 32'(PAUSE_LIMIT_CYCLES - 1))
        else $error("flow control released before the limit");
    irq_rel_a: assert property ($rose(irq_out_low) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("interrupt released without a write");

    // main scenarios reached
    cover property (flow_ctrl_invalidate);
    cover property ($fell(irq_out_low));
    cover property (p3_egress_queue_valid && p3_egress_queue_grant == 4'h1);
endmodule : sqic_regs_sva

bind sqic_regs sqic_regs_sva #(.PAUSE_LIMIT_CYCLES(PAUSE_LIMIT_CYCLES)) chk (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pause_active,
    .flow_ctrl_invalidate, .p2_two_queue, .p2_egress_queue_req, .p2_egress_queue_take,
    .p2_egress_queue_grant, .p2_egress_queue_valid, .p3_egress_queue_req,
    .p3_egress_queue_take, .p3_egress_queue_grant, .p3_egress_queue_valid,
    .irq_out_low, .regulator_disable
);
`default_nettype wire

//--- sqic_sched.sv
`timescale 1ns/100ps
`default_nettype none
module sqic_sched
    import sqic_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       weighted,
    input  wire logic       two_queue,
    input  wire logic [3:0] queue_req,
    input  wire logic       take,
    output logic      [3:0] grant,
    output logic            grant_valid
);
    // ------------------------------------------------------------------
    // selection
    // ------------------------------------------------------------------
    logic [3:0] credit [4];
    logic [3:0] eff_req;
    logic [3:0] credit_nz;
    logic [3:0] elig;
    logic       reload;
    logic [3:0] pick;
    logic       fire;

    function automatic logic [3:0] sqic_top1(input logic [3:0] v);
        logic [3:0] r;
        r = 4'h0;
        if (v[3]) r = 4'h8;
        else if (v[2]) r = 4'h4;
        else if (v[1]) r = 4'h2;
        else if (v[0]) r = 4'h1;
        return r;
    endfunction : sqic_top1

    // two-queue ports use only the two low queues
    assign eff_req   = two_queue ? {2'b00, queue_req[1:0]} : queue_req;
    assign credit_nz = {|credit[3], |credit[2], |credit[1], |credit[0]};
    assign elig      = eff_req & credit_nz;
    assign reload    = weighted && (elig == 4'h0);
    // strict: highest requester; weighted: highest with credit left
    assign pick      = (!weighted || reload) ? sqic_top1(eff_req) : sqic_top1(elig);
    assign fire      = take && (eff_req != 4'h0);

    // ------------------------------------------------------------------
    // credits, refilled 8:4:2:1 (2:1 on two-queue ports) per round
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            credit[3] <= WEIGHT_Q3[3:0];
            credit[2] <= WEIGHT_Q2[3:0];
            credit[1] <= WEIGHT_Q1[3:0];
            credit[0] <= WEIGHT_Q0[3:0];
        end else if (fire && weighted) begin
            credit[3] <= (reload ? WEIGHT_Q3[3:0] : credit[3]) - {3'b000, pick[3]};
            credit[2] <= (reload ? WEIGHT_Q2[3:0] : credit[2]) - {3'b000, pick[2]};
            credit[1] <= (reload ? WEIGHT_Q1[3:0] : credit[1]) - {3'b000, pick[1]};
            credit[0] <= (reload ? WEIGHT_Q0[3:0] : credit[0]) - {3'b000, pick[0]};
        end
    end

    // grant is a one-cycle registered pulse per take
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grant       <= 4'h0;
            grant_valid <= 1'b0;
        end else begin
            grant       <= fire ? pick : 4'h0;
            grant_valid <= fire;
        end
    end
endmodule : sqic_sched
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sqic_pkg::*;
    logic       clk, rst_b, reg_wr, reg_rd, pause_active, flow_ctrl_invalidate;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       p1_copper_link, p1_mii_link, p2_copper_link, p3_mii_link, global_prio;
    logic [2:0] p2_upper_sel;
    logic       p2_two_queue, p2_egress_queue_take, p2_egress_queue_valid;
    logic       p3_two_queue, p3_egress_queue_take, p3_egress_queue_valid;
    logic [3:0] p2_egress_queue_req, p2_egress_queue_grant;
    logic [3:0] p3_egress_queue_req, p3_egress_queue_grant;
    logic       irq_out_low, regulator_disable;
    int         bad_count, comparisons;

    // short pause limit keeps the run brief
    sqic_regs #(.PAUSE_LIMIT_CYCLES(16)) dut (.*);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] act, input logic [7:0] exp);
        comparisons++;
        if (act !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        check(reg_rdata, e);
    endtask : rd_chk

    // n takes in a row; exp holds the grant count of queue i in byte i
    task automatic sched(input logic p3, input logic [3:0] req, input int n,
                         input logic [31:0] exp);
        logic [7:0] cnt [5];
        cnt = '{default: 8'h00};
        p2_egress_queue_req = req;
        p3_egress_queue_req = req;
        @(negedge clk);
        if (p3) p3_egress_queue_take = 1'b1;
        else p2_egress_queue_take = 1'b1;
        for (int k = 0; k <= n; k++) begin
            @(negedge clk);
            if (k == n - 1) {p2_egress_queue_take, p3_egress_queue_take} = 2'b00;
            for (int i = 0; i < 4; i++) begin
                if ((p3 ? p3_egress_queue_grant[i] : p2_egress_queue_grant[i]) === 1'b1) cnt[i]++;
            end
            if ((p3 ? p3_egress_queue_valid : p2_egress_queue_valid) === 1'b1) cnt[4]++;
        end
        for (int i = 0; i < 4; i++) check(cnt[i], exp[8*i+:8]);
        check(cnt[4], 8'(n));
    endtask : sched

    task automatic complete_run();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        static logic [7:0] ra [11] = '{8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD,
                                 8'hC0, 8'hC1, 8'h10};
        static logic [7:0] rv [11] = '{8'h81, 8'h88, 8'h84, 8'h82, 8'h81, 8'h00, 8'h00, 8'h00,
                                 8'h03, 8'h00, 8'h00};
        {rst_b, reg_wr, reg_rd, pause_active, global_prio} = 5'h00;
        {reg_addr, reg_wdata, p2_upper_sel} = 19'h00000;
        {p1_copper_link, p1_mii_link, p2_copper_link, p3_mii_link} = 4'h0;
        {p2_two_queue, p2_egress_queue_take, p3_two_queue, p3_egress_queue_take} = 4'h0;
        {p2_egress_queue_req, p3_egress_queue_req} = 8'h00;
        bad_count = 0;
        comparisons = 0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 11; i++) rd_chk(ra[i], rv[i]);
        // weighted ratios from fresh credits
        sched(1'b1, 4'hF, 15, 32'h08040201);
        p3_two_queue = 1'b1;
        sched(1'b1, 4'hF, 6, 32'h00000402);
        p3_two_queue = 1'b0;
        global_prio = 1'b1;
        wr_reg(8'hB6, 8'h00);
        sched(1'b0, 4'hF, 15, 32'h08040201);
        // strict order once every select and the global bit are clear
        global_prio = 1'b0;
        sched(1'b0, 4'h5, 4, 32'h00040000);
        p2_two_queue = 1'b1;
        sched(1'b0, 4'hD, 3, 32'h00000003);
        p2_two_queue = 1'b0;
        for (int i = 0; i < 4; i++) wr_reg(8'hB7 + 8'(i), 8'h7F);
        rd_chk(8'hB7, 8'h08);
        sched(1'b1, 4'h3, 3, 32'h00000300);
        // read-only and partly writable places
        wr_reg(8'hC0, 8'hFF);
        rd_chk(8'hC0, 8'h03);
        wr_reg(8'hC1, 8'hFF);
        rd_chk(8'hC1, 8'h40);
        check({7'h00, regulator_disable}, 8'h01);
        wr_reg(8'hC1, 8'h00);
        check({7'h00, regulator_disable}, 8'h00);
        // link change: enable first, clear, then wait
        wr_reg(8'hBB, 8'h80);
        wr_reg(8'hBC, 8'hFF);
        rd_chk(8'hBB, 8'h80);
        p2_copper_link = 1'b1;
        repeat (8) @(negedge clk);
        rd_chk(8'hBC, 8'h82);
        check({7'h00, irq_out_low}, 8'h00);
        wr_reg(8'hBC, 8'h02);
        rd_chk(8'hBC, 8'h80);
        check({7'h00, irq_out_low}, 8'h00);
        wr_reg(8'hBC, 8'h80);
        rd_chk(8'hBC, 8'h00);
        check({7'h00, irq_out_low}, 8'h01);
        {p3_mii_link, p1_mii_link} = 2'b11;
        repeat (8) @(negedge clk);
        rd_chk(8'hBC, 8'h05);
        check({7'h00, irq_out_low}, 8'h01);
        wr_reg(8'hBB, 8'h05);
        repeat (2) @(negedge clk);
        check({7'h00, irq_out_low}, 8'h00);
        wr_reg(8'hBC, 8'h05);
        rd_chk(8'hBC, 8'h00);
        p1_copper_link = 1'b1;
        repeat (8) @(negedge clk);
        rd_chk(8'hBC, 8'h81);
        check({7'h00, irq_out_low}, 8'h00);
        // pause limit: two pulses in 40 paused cycles, none when disabled
        for (int m = 1; m >= 0; m--) begin
            int pulses;
            pulses = 0;
            wr_reg(8'hBD, 8'(m));
            pause_active = 1'b1;
            repeat (40) begin
                @(negedge clk);
                if (flow_ctrl_invalidate === 1'b1) pulses++;
            end
            pause_active = 1'b0;
            check(8'(pulses), 8'(2 * m));
        end
        complete_run();
    end
endmodule : tb
`default_nettype wire
